/* hw/hpp_host_port.sv */
// Purpose: pin logic of the 16-bit host parallel port
// Assumes: host pins asynchronous to MCLK, synchronised by two flops
// Notes:   register behaviour behind the port lives elsewhere
`timescale 1ns/1ps
module hpp_host_port
   import hpp_pkg::*;
#(
   parameter logic SILICON_REV = HPP_REV_LATER
)(
   input  wire logic       MCLK,
   input  wire logic       NRST,
   // configuration
   input  wire logic       PORT_ENABLE,
   input  wire logic       UPPER_HW,
   input  wire logic [7:0] UPPER_GPO_DIR,
   input  wire logic [7:0] UPPER_GPO_VAL,
   input  wire logic [1:0] LINE11_DIR,
   input  wire logic [1:0] LINE11_VAL,
   input  wire hpp_cfg_t   CFG,
   // host pins
   input  wire logic       HOST_CHIP_SELECT_A,
   input  wire logic       HOST_CHIP_SELECT_B,
   input  wire logic       DUAL_STROBE_SELECT,
   input  wire logic       HOST_READ_WRITE,
   input  wire logic       HOST_STROBE_1,
   input  wire logic       HOST_STROBE_2,
   input  wire logic       STROBE_POLARITY_STRAP,
   input  wire logic       HOST_ACKNOWLEDGE_IN,
   input  wire logic       HOST_ADDR_TOP_BIT,
   input  wire logic [2:0] HOST_ADDR_LOW_BITS,
   input  wire logic [7:0] HOST_DATA_UPPER_IN,
   input  wire logic [7:0] HOST_DATA_LOWER_IN,
   output logic      [7:0] HOST_DATA_UPPER_OUT,
   output logic      [7:0] HOST_DATA_UPPER_OE_N,
   output logic      [7:0] HOST_DATA_LOWER_OUT,
   output logic            HOST_DATA_LOWER_OE_N,
   input  wire logic [1:0] LINE11_IN,
   output logic      [1:0] LINE11_OUT,
   output logic      [1:0] LINE11_OE_N,
   output logic      [1:0] LINE11_GPI,
   output logic      [7:0] PORT_C_LOW_INPUTS,
   // requests: [0] single or transmit, [1] receive
   input  wire logic [1:0] REQ_ASSERT,
   output logic      [1:0] REQ_OUT,
   output logic      [1:0] REQ_OE_N,
   // internal side
   input  wire logic [15:0] RD_DATA,
   output logic            RD_STB,
   output logic            WR_STB,
   output logic      [2:0] REG_ADDR,
   output logic     [15:0] WR_DATA,
   output logic            ACK_SEEN,
   output logic            STROBE_POL
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      hpp_pins_t  s1;
      hpp_pins_t  s2;
      logic       strap_done;
      logic [1:0] strap_wait;
      logic       pol;
      hpp_state_t st;
      logic       rd_stb;
      logic       wr_stb;
      logic [2:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic       lo_oe_n;
      logic [7:0] hi_out;
      logic [7:0] hi_oe_n;
      logic [1:0] l11_out;
      logic [1:0] l11_oe_n;
      logic [1:0] l11_gpi;
      logic [1:0] l11_s1;
      logic [1:0] l11_s2;
      logic [7:0] gpi;
      logic [1:0] req_out;
      logic [1:0] req_oe_n;
      logic       ack;
   } hpp_reg_t;

   hpp_reg_t r;
   hpp_reg_t next_r;

   logic cs;
   logic strb1_on;
   logic strb2_on;
   logic rd_on;
   logic wr_on;
   logic ack_on;
   logic [1:0] req_lvl;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   // all pin reads use the second synchroniser stage only
   always_comb begin
      next_r = r;
      next_r.s1 = '{cs_a: HOST_CHIP_SELECT_A, cs_b: HOST_CHIP_SELECT_B,
                    dds: DUAL_STROBE_SELECT, rw: HOST_READ_WRITE,
                    strb1: HOST_STROBE_1, strb2: HOST_STROBE_2,
                    ack: HOST_ACKNOWLEDGE_IN, strap: STROBE_POLARITY_STRAP,
                    addr: HOST_ADDR_LOW_BITS, dhi: HOST_DATA_UPPER_IN,
                    dlo: HOST_DATA_LOWER_IN};
      next_r.s2 = r.s1;
      // strap capture once
      // wait until the synchroniser holds a post-reset sample, not its reset zero
      next_r.strap_wait = {r.strap_wait[0], 1'b1};
      if (r.strap_wait[1] && !r.strap_done) begin
         next_r.strap_done = 1'b1;
         next_r.pol        = r.s2.strap;
      end
      cs = PORT_ENABLE && ((r.s2.cs_a == CFG.cs_a_hi) || (r.s2.cs_b == CFG.cs_b_hi));
      strb1_on = r.strap_done && (r.s2.strb1 == r.pol);
      strb2_on = r.strap_done && (r.s2.strb2 == r.pol);
      if (r.s2.dds) begin
         rd_on = strb1_on;
         wr_on = strb2_on && !strb1_on;
      end else begin
         rd_on = strb1_on && r.s2.rw;
         wr_on = strb1_on && !r.s2.rw;
      end
      rd_on = rd_on && cs;
      wr_on = wr_on && cs;
      next_r.rd_stb = 1'b0;
      next_r.wr_stb = 1'b0;
      case (r.st)
         HPP_IDLE: begin
            if (rd_on) begin
               next_r.st     = HPP_READ;
               next_r.rd_stb = 1'b1;
               next_r.addr   = r.s2.addr;
            end else if (wr_on) begin
               next_r.st   = HPP_WRITE;
               next_r.addr = r.s2.addr;
            end
         end
         HPP_READ: begin
            next_r.rdata = RD_DATA;
            if (!rd_on) begin
               next_r.st = HPP_IDLE;
            end
         end
         HPP_WRITE: begin
            // data taken at end of strobe
            next_r.wdata = {r.s2.dhi, r.s2.dlo};
            if (!wr_on) begin
               next_r.st     = HPP_IDLE;
               next_r.wr_stb = 1'b1;
            end
         end
         default: next_r.st = HPP_IDLE;
      endcase
      next_r.lo_oe_n = !((next_r.st == HPP_READ) && rd_on);
      // upper byte: host function or gpio
      if (UPPER_HW && PORT_ENABLE) begin
         next_r.hi_out  = r.rdata[15:8];
         next_r.hi_oe_n = {HPP_BYTE_W{next_r.lo_oe_n}};
      end else begin
         next_r.hi_out  = UPPER_GPO_VAL;
         next_r.hi_oe_n = ~UPPER_GPO_DIR;
      end
      next_r.gpi = r.s2.dhi;
      // line 11 only usable on later revision
      // line 11 pins are asynchronous, two flops before use
      next_r.l11_s1 = LINE11_IN;
      next_r.l11_s2 = r.l11_s1;
      if (SILICON_REV == HPP_REV_LATER) begin
         next_r.l11_out  = LINE11_VAL;
         next_r.l11_oe_n = ~LINE11_DIR;
         next_r.l11_gpi  = r.l11_s2;
      end else begin
         next_r.l11_out  = 2'h0;
         next_r.l11_oe_n = 2'h3;
         next_r.l11_gpi  = 2'h0;
      end
      ack_on = PORT_ENABLE && !CFG.dual_req && (r.s2.ack == CFG.ack_hi);
      next_r.ack = ack_on;
      // second request used in dual mode only
      req_lvl[0] = PORT_ENABLE && REQ_ASSERT[0];
      req_lvl[1] = PORT_ENABLE && CFG.dual_req && REQ_ASSERT[1];
      for (int i = 0; i < 2; i++) begin
         next_r.req_out[i] = req_lvl[i] ~^ CFG.req_hi;
         if (CFG.req_od) begin
            // never pulls while the port is still reserved
            next_r.req_out[i]  = 1'b0;
            next_r.req_oe_n[i] = !PORT_ENABLE || (req_lvl[i] ~^ CFG.req_hi);
         end else begin
            next_r.req_oe_n[i] = !PORT_ENABLE;
         end
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   // reset: all lines undriven inputs
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         r          <= '0;
         r.st       <= HPP_IDLE;
         r.lo_oe_n  <= 1'b1;
         r.hi_oe_n  <= 8'hff;
         r.l11_oe_n <= 2'h3;
         r.req_oe_n <= 2'h3;
      end else begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------------
   // outputs, all from flops
   // ------------------------------------------------------------------
   assign HOST_DATA_UPPER_OUT  = r.hi_out;
   assign HOST_DATA_UPPER_OE_N = r.hi_oe_n;
   assign HOST_DATA_LOWER_OUT  = r.rdata[7:0];
   assign HOST_DATA_LOWER_OE_N = r.lo_oe_n;
   assign LINE11_OUT           = r.l11_out;
   assign LINE11_OE_N          = r.l11_oe_n;
   assign LINE11_GPI           = r.l11_gpi;
   assign PORT_C_LOW_INPUTS    = r.gpi;
   assign REQ_OUT              = r.req_out;
   assign REQ_OE_N             = r.req_oe_n;
   assign RD_STB               = r.rd_stb;
   assign WR_STB               = r.wr_stb;
   assign REG_ADDR             = r.addr;
   assign WR_DATA              = r.wdata;
   assign ACK_SEEN             = r.ack;
   assign STROBE_POL           = r.pol;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   property p_strap_hold;
      @(posedge MCLK) disable iff (!NRST) r.strap_done |=> $stable(r.pol);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("polarity changed");

   property p_no_cs_no_rd;
      @(posedge MCLK) disable iff (!NRST) (r.st == HPP_IDLE && !cs) |=> !r.rd_stb;
   endproperty
   a_no_cs_no_rd: assert property (p_no_cs_no_rd) else $error("read without select");

   property p_drive_read;
      @(posedge MCLK) disable iff (!NRST) !r.lo_oe_n |-> r.st == HPP_READ;
   endproperty
   a_drive_read: assert property (p_drive_read) else $error("bus driven outside read");

   property p_od_high;
      @(posedge MCLK) disable iff (!NRST) (!r.req_oe_n[0] && $past(CFG.req_od)) |-> !r.req_out[0];
   endproperty
   a_od_high: assert property (p_od_high) else $error("open drain drove high");

   property p_rx_single;
      @(posedge MCLK) disable iff (!NRST) (!CFG.dual_req && PORT_ENABLE && !CFG.req_od
         && $stable(CFG)) |=> r.req_out[1] == !$past(CFG.req_hi);
   endproperty
   a_rx_single: assert property (p_rx_single) else $error("receive request in single mode");

   property p_wr_after;
      @(posedge MCLK) disable iff (!NRST) r.wr_stb |-> $past(r.st) == HPP_WRITE;
   endproperty
   a_wr_after: assert property (p_wr_after) else $error("write strobe without write");

   // read start and bus drive come from the same decision
   sequence s_rd_start;
      r.rd_stb;
   endsequence
   sequence s_bus_driven;
      !r.lo_oe_n && r.st == HPP_READ;
   endsequence
   property p_rd_drives;
      @(posedge MCLK) disable iff (!NRST) s_rd_start |-> s_bus_driven;
   endproperty
   a_rd_drives: assert property (p_rd_drives) else $error("read strobe without bus drive");

   property p_strap_take;
      @(posedge MCLK) disable iff (!NRST) $rose(r.strap_done) |-> r.pol == $past(r.s2.strap);
   endproperty
   a_strap_take: assert property (p_strap_take) else $error("strap not taken from pin");

   property p_rd_dir;
      @(posedge MCLK) disable iff (!NRST) r.rd_stb |-> ($past(r.s2.dds) || $past(r.s2.rw));
   endproperty
   a_rd_dir: assert property (p_rd_dir) else $error("single strobe read without read level");

endmodule

/* hw/hpp_pkg.sv */
// Purpose: shared constants and carriers for the host parallel port pin logic
// Assumes: one clock, MCLK at 25 MHz
// Notes:   pin-level bit positions within port B and port C views
package hpp_pkg;

   // ------------------------------------------------------------------
   // widths and reset values
   // ------------------------------------------------------------------
   localparam int          HPP_BYTE_W      = 8;
   localparam int          HPP_ADDR_W      = 3;
   localparam logic [7:0]  HPP_BYTE_RST    = 8'h00;
   localparam logic        HPP_STRAP_RST   = 1'b0;
   localparam logic [2:0]  HPP_ADDR_RST    = 3'h0;
   // revision code of the later silicon; value is arbitrary
   localparam logic        HPP_REV_LATER   = 1'b1;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   // host configuration bits, all active high
   typedef struct packed {
      logic cs_a_hi;      // chip select a active high
      logic cs_b_hi;      // chip select b active high
      logic req_hi;       // request outputs active high
      logic ack_hi;       // acknowledge active high
      logic req_od;       // request outputs open drain
      logic dual_req;     // dual request mode
   } hpp_cfg_t;

   // synchronised host pins
   typedef struct packed {
      logic       cs_a;
      logic       cs_b;
      logic       dds;
      logic       rw;
      logic       strb1;   // single strobe / read strobe pin
      logic       strb2;   // write strobe pin
      logic       ack;
      logic       strap;
      logic [2:0] addr;
      logic [7:0] dhi;
      logic [7:0] dlo;
   } hpp_pins_t;

   // access state, one-hot
   typedef enum logic [2:0] {
      HPP_IDLE  = 3'b001,
      HPP_READ  = 3'b010,
      HPP_WRITE = 3'b100
   } hpp_state_t;

endpackage

/* tb/hpp_host_model.sv */
// Purpose: host processor model on the port pins
// Assumes: one access at a time, bench clock
// Notes:   a released bus shows a toggling pattern
`timescale 1ns/1ps
module hpp_host_model (
   input  wire logic        MCLK,
   input  wire logic [15:0] DEV_OUT,
   input  wire logic [15:0] DEV_OE_N,
   output logic             CS_A,
   output logic             CS_B,
   output logic             RW,
   output logic             S1,
   output logic             S2,
   output logic      [2:0]  ADDR,
   output logic      [15:0] BUS
);
   logic [15:0] hd = 16'h0000;
   logic        drv = 1'b0;
   logic [15:0] last = 16'h0000;
   assign BUS = (~DEV_OE_N & DEV_OUT) | (DEV_OE_N & (drv ? hd : ~last));
   // inverted history so a float never passes for stale data
   always @(posedge MCLK) last <= BUS;
   task automatic idle(input logic pol);
      S1 = !pol;
      S2 = !pol;
      drv = 1'b0;
      {CS_A, CS_B, RW, ADDR} = 6'h00;
   endtask
   task automatic set_bus(input logic [15:0] d);
      hd = d;
      drv = 1'b1;
   endtask
   // strobed access, top address bit low
   task automatic access(input logic rd, dual, pol, input logic [1:0] cs,
                         input logic [2:0] a, input logic [15:0] d, output logic [15:0] q);
      @(negedge MCLK);
      {CS_A, CS_B, RW, ADDR} = {cs, rd, a};
      hd = d;
      drv = !rd;
      if (!dual || rd) S1 = pol;
      else S2 = pol;
      repeat (8) @(negedge MCLK);
      q = BUS;
      S1 = !pol;
      S2 = !pol;
      // select and data held past the release
      repeat (5) @(negedge MCLK);
      idle(pol);
      repeat (2) @(negedge MCLK);
   endtask
endmodule

/* tb/hpp_host_port_tb_top.sv */
// Purpose: self-checking bench for the host port pin logic
// Assumes: host select, strobe, read/write, address and data pins driven by the host model; strap, dds and ack by the bench
// Notes:   random configs under both strap values
`timescale 1ns/1ps
module hpp_host_port_tb_top import hpp_pkg::*; ;
   logic        mclk = 1'b0, nrst = 1'b0, en = 1'b0, uhw = 1'b0, dds = 1'b0, strap = 1'b0, ack = 1'b0;
   logic [7:0]  gdir = 8'h00, gval = 8'h00, u_out, u_oe, l_out, pcl;
   logic [1:0]  ldir = 2'h0, lval = 2'h0, lin = 2'h0, rq_a = 2'h0, l11_out, l11_oe, l11_gpi, rq_out, rq_oe, lv;
   logic [15:0] rdd = 16'h0000, bus, wr_d, cur_d = 16'h0000;
   logic [2:0]  addr, reg_a, cur_a = 3'h0;
   logic        cs_a, cs_b, rw, s1, s2, l_oe, rd_stb, wr_stb, ack_s, spol;
   hpp_cfg_t    cfg = '0;
   int          err_count = 0, compares = 0, rd_cnt = 0, wr_cnt = 0;
   hpp_host_port u_hpp_host_port (.MCLK(mclk), .NRST(nrst), .PORT_ENABLE(en), .UPPER_HW(uhw),
      .UPPER_GPO_DIR(gdir), .UPPER_GPO_VAL(gval), .LINE11_DIR(ldir), .LINE11_VAL(lval), .CFG(cfg),
      .HOST_CHIP_SELECT_A(cs_a), .HOST_CHIP_SELECT_B(cs_b), .DUAL_STROBE_SELECT(dds),
      .HOST_READ_WRITE(rw), .HOST_STROBE_1(s1), .HOST_STROBE_2(s2), .STROBE_POLARITY_STRAP(strap),
      .HOST_ACKNOWLEDGE_IN(ack), .HOST_ADDR_TOP_BIT(1'b0), .HOST_ADDR_LOW_BITS(addr), // top bit low
      .HOST_DATA_UPPER_IN(bus[15:8]), .HOST_DATA_LOWER_IN(bus[7:0]), .HOST_DATA_UPPER_OUT(u_out),
      .HOST_DATA_UPPER_OE_N(u_oe), .HOST_DATA_LOWER_OUT(l_out), .HOST_DATA_LOWER_OE_N(l_oe),
      .LINE11_IN(lin), .LINE11_OUT(l11_out), .LINE11_OE_N(l11_oe), .LINE11_GPI(l11_gpi),
      .PORT_C_LOW_INPUTS(pcl), .REQ_ASSERT(rq_a), .REQ_OUT(rq_out), .REQ_OE_N(rq_oe), .RD_DATA(rdd),
      .RD_STB(rd_stb), .WR_STB(wr_stb), .REG_ADDR(reg_a), .WR_DATA(wr_d), .ACK_SEEN(ack_s),
      .STROBE_POL(spol));
   hpp_host_model u_hpp_host_model (.MCLK(mclk), .DEV_OUT({u_out, l_out}), .DEV_OE_N({u_oe, {8{l_oe}}}),
      .CS_A(cs_a), .CS_B(cs_b), .RW(rw), .S1(s1), .S2(s2), .ADDR(addr), .BUS(bus));
   initial forever #20 mclk = ~mclk;
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      compares++;
      if (e !== s) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic end_sim;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // pulse counts; address checked at each pulse, write data at each write pulse
   always @(negedge mclk) begin
      if (rd_stb === 1'b1 || wr_stb === 1'b1) chk("addr", cur_a, reg_a);
      rd_cnt += int'(rd_stb === 1'b1);
      wr_cnt += int'(wr_stb === 1'b1);
      if (wr_stb === 1'b1) chk("wdata", cur_d, wr_d);
   end
   task automatic do_reset(input logic p);
      @(negedge mclk);
      nrst = 1'b0;
      strap = p;
      u_hpp_host_model.idle(p);
      repeat (10) @(negedge mclk);
      chk("rst_oe", 16'h07ff, {u_oe, l_oe, rq_oe});
      nrst = 1'b1;
      repeat (3) @(negedge mclk);
      chk("pol", p, spol);
   endtask
   task automatic xfer(input logic rd, input logic [1:0] cs);
      int          r0, w0;
      logic        ok;
      logic [15:0] q;
      r0 = rd_cnt;
      w0 = wr_cnt;
      ok = en & ((cs[1] == cfg.cs_a_hi) | (cs[0] == cfg.cs_b_hi));
      {cur_a, cur_d, rdd} = 35'({$urandom, $urandom});
      u_hpp_host_model.access(rd, dds, strap, cs, cur_a, cur_d, q);
      chk("rd_cnt", 16'(ok & rd), 16'(rd_cnt - r0));
      chk("wr_cnt", 16'(ok & !rd), 16'(wr_cnt - w0));
      if (ok & rd) chk("rdata", rdd, q);
   endtask
   // ---------------------------------------------------------------
   // stimulus: accesses, then requests and shared lines
   // ---------------------------------------------------------------
   initial begin
      u_hpp_host_model.idle(1'b0);
      void'($urandom(47410));
      for (int p = 0; p < 2; p++) begin
         do_reset(1'(p));
         for (int i = 0; i < 24; i++) begin
            cfg = hpp_cfg_t'($urandom);
            {en, dds, uhw} = {|2'($urandom), 1'($urandom), 1'b1};
            xfer(1'($urandom), 2'($urandom));
         end
         {en, uhw} = 2'b10;
         for (int i = 0; i < 16; i++) begin
            {cfg, rq_a, ack, gdir, gval, ldir, lval, lin} = 31'($urandom);
            cur_d = 16'($urandom);
            u_hpp_host_model.set_bus(cur_d);
            repeat (4) @(negedge mclk);
            lv = rq_a & {cfg.dual_req, 1'b1};
            lv = cfg.req_hi ? lv : ~lv;
            chk("req_out", cfg.req_od ? 2'b00 : lv, rq_out);
            chk("req_oe", cfg.req_od ? lv : 2'b00, rq_oe);
            chk("ack", !cfg.dual_req && (ack == cfg.ack_hi), ack_s);
            chk("gpo", {~gdir, gval & gdir}, {u_oe, u_out & gdir});
            chk("gpi", (gdir & gval) | (~gdir & cur_d[15:8]), pcl);
            chk("line11", {~ldir, lval & ldir, lin}, {l11_oe, l11_out & ldir, l11_gpi});
            chk("lo_oe", 1'b1, l_oe);
         end
         u_hpp_host_model.idle(1'(p));
      end
      end_sim();
   end
   // hang guard, far beyond the expected run
   initial begin
      #400000;
      err_count++;
      end_sim();
   end
endmodule
